// ### adctr_core_model.sv
// behavioural model of the analog core behind the control block
`default_nettype none
module adctr_core_model (
    input wire logic clk_in, // converter clock
    input wire logic rst_b_in, // reset, active low
    input wire logic start_in, // start pulse
    input wire logic [2:0] channel_in, // channel to convert
    input wire logic [5:0] delay_in, // cycles until the answer
    output logic done_out, // one-cycle completion pulse
    output logic [9:0] result_out // result, valid with done only
);
    logic busy_q; // conversion running
    logic [5:0] cnt_q; // cycles left
    logic [2:0] ch_q; // channel held for the result
    // a new start aborts the running conversion, as the real core does
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_q <= 1'b0;
            cnt_q <= 6'h00;
            ch_q <= 3'h0;
        end else if (start_in) begin
            busy_q <= 1'b1;
            cnt_q <= delay_in;
            ch_q <= channel_in;
        end else if (busy_q) begin
            busy_q <= (cnt_q != 6'h00);
            cnt_q <= cnt_q - 6'h01;
        end
    end
    // inverted outside the done cycle so a stale value never passes
    assign done_out = busy_q && (cnt_q == 6'h00);
    assign result_out = done_out ? {ch_q, 7'h55} : ~{ch_q, 7'h55};
endmodule
`default_nettype wire

// ### adctr_pkg.sv
// constants and types for the converter trigger, result and status block
`default_nettype none
package adctr_pkg;
    // register byte addresses on the peripheral bus
    localparam logic [31:0] ADDR_CTRL = 32'h4001C000; // converter_control
    localparam logic [31:0] ADDR_GRES = 32'h4001C004; // latest_result
    localparam logic [31:0] ADDR_SRC = 32'h4001C008; // channel_source_select
    localparam logic [31:0] ADDR_MASK = 32'h4001C00C; // channel_irq_mask
    localparam logic [31:0] ADDR_CRES0 = 32'h4001C010; // channel_result_word 0
    localparam logic [31:0] ADDR_STEP = 32'h00000004; // word stride
    localparam logic [31:0] ADDR_STAT = 32'h4001C030; // all_channel_flags

    // control register layout
    localparam int CTRL_W = 28; // bits 27:0 stored, 31:28 read zero
    localparam int SEL_LSB = 0; // channel select mask
    localparam int BURST_BIT = 16; // repeated scan
    localparam int SINGLE_BIT = 20; // single pass
    localparam int START_LSB = 23; // start field 26:23
    localparam int EDGE_BIT = 27; // 0 rising, 1 falling
    localparam logic [CTRL_W-1:0] CTRL_RST = 28'h0000000;

    // start field codes
    localparam logic [3:0] ST_NONE = 4'h0;
    localparam logic [3:0] ST_NOW = 4'h2;
    localparam logic [3:0] ST_EXT0 = 4'h4;
    localparam logic [3:0] ST_CMP = 4'h5;
    localparam logic [3:0] ST_EXT1 = 4'h6;
    localparam logic [3:0] ST_WT0 = 4'h8;
    localparam logic [3:0] ST_WT1 = 4'hA;
    localparam logic [3:0] ST_NT0 = 4'hC;
    localparam logic [3:0] ST_NT1 = 4'hE;

    // trigger vector bit positions
    localparam int TR_EXT0 = 0;
    localparam int TR_CMP = 1;
    localparam int TR_EXT1 = 2;
    localparam int TR_WT0 = 3;
    localparam int TR_WT1 = 4;
    localparam int TR_NT0 = 5;
    localparam int TR_NT1 = 6;
    localparam int TR_N = 7;

    // result word layout
    localparam int RES_LSB = 6; // 15:6 result
    localparam int CHN_LSB = 24; // 26:24 channel
    localparam int OVR_BIT = 30;
    localparam int DONE_BIT = 31;

    // source select and status layout
    localparam int SRC_LSB = 10; // 15:10 three 2-bit fields
    localparam logic [5:0] SRC_RST = 6'h00;
    localparam int STAT_OVR_LSB = 8;
    localparam int STAT_IRQ_BIT = 16;
    localparam logic [7:0] MASK_RST = 8'h00;

    typedef enum logic {ST_IDLE = 1'b0, ST_BUSY = 1'b1} adctr_state_e;
endpackage
`default_nettype wire

// ### adctr_top.sv
// converter start control, result publishing and status mirror, APB slave
// Function
// - start field controls start when not scanning
// - code 0x2 starts conversion at once
// - codes 0x4/0x6 trigger on external pins
// - code 0x5 triggers on comparator output
// - codes 0x8/0xA/0xC/0xE trigger on timer matches
// - edge bit picks rising or falling
// - latest result holds 10-bit fraction
// - unused latest result bits read zero
// - latest result reports its channel number
// - lost-result flag set in scan, read clears
// - done flag set; read or control write clears
// - control write mid-conversion sets done, restarts
// - channel 5 source select field
// - channel 6 source select field
// - channel 7 source select field
// - status shows eight per-channel done flags
// - status shows eight per-channel lost flags
// - combined flag is masked OR of done
// - single pass clears scan bit, then stops
// - per-channel mask gates combined flag
//
// Our own choice: the APB slave port.
`default_nettype none
module adctr_top (
    input wire logic sys_clk_in, // 200 MHz peripheral clock
    input wire logic rst_b_in, // async reset, active low
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb access phase
    input wire logic pwrite_in, // apb direction, 1 write
    input wire logic [31:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error, unmapped address
    input wire logic ext_trigger_in0_in, // external trigger pin 0
    input wire logic ext_trigger_in1_in, // external trigger pin 1
    input wire logic comparator_in, // analog comparator output
    input wire logic wide_timer_match0_in, // 32-bit timer match 0
    input wire logic wide_timer_match1_in, // 32-bit timer match 1
    input wire logic narrow_timer_match0_in, // 16-bit timer match 0
    input wire logic narrow_timer_match1_in, // 16-bit timer match 1
    input wire logic core_done_in, // core finished, one-cycle pulse
    input wire logic [9:0] core_result_in, // core result, valid with done
    output logic conv_start_out, // start pulse to core
    output logic [2:0] conv_channel_out, // channel to convert
    output logic converter_busy_out, // conversion running
    output logic [1:0] ch5_source_out, // channel 5 analog switch
    output logic [1:0] ch6_source_out, // channel 6 analog switch
    output logic [1:0] ch7_source_out // channel 7 analog switch
);
    // whole state of the block
    typedef struct packed {
        logic [adctr_pkg::TR_N-1:0] sync1; // first synchroniser stage
        logic [adctr_pkg::TR_N-1:0] sync2; // second synchroniser stage
        logic trig_prev; // previous sample of selected trigger
        logic [adctr_pkg::CTRL_W-1:0] ctrl; // converter_control
        logic [5:0] src; // channel_source_select fields
        logic [7:0] mask; // channel_irq_mask
        adctr_pkg::adctr_state_e state; // idle or converting
        logic [2:0] ch; // channel in conversion or next in scan
        logic start; // start pulse
        logic [7:0][9:0] res; // per-channel results
        logic [7:0] done; // per-channel done flags
        logic [7:0] ovr; // per-channel lost flags
        logic [9:0] g_res; // latest result
        logic [2:0] g_ch; // latest channel
        logic g_done; // latest done flag
        logic g_ovr; // latest lost flag
        logic [31:0] prdata; // read data
        logic pready; // ready
        logic pslverr; // error
    } adctr_regs_s;

    adctr_regs_s q; // registered state
    adctr_regs_s d; // next state

    // comb helpers, assigned in the process; trigger and read mux helpers where used, the rest at the top
    logic [adctr_pkg::TR_N-1:0] trig_raw; // unsynchronised trigger vector
    logic trig_sel; // selected trigger sample
    logic trig_ok; // start code names a trigger source
    logic trig_edge; // qualifying edge seen
    logic acc_first; // first access cycle, data capture and read clears
    logic acc_end; // apb access completes this edge
    logic wr_ctrl; // control register written
    logic rd_gres; // latest result read
    logic hit; // address maps to a register
    logic [31:0] rdata; // read mux
    logic [3:0] start_code; // current start field
    logic burst; // repeated scan on
    logic [7:0] sel_mask; // channels selected
    logic [7:0] new_sel; // channel select being written
    logic go; // begin conversion
    logic [2:0] go_ch; // channel to begin on
    logic [2:0] nxt; // next scan channel

    // lowest selected channel; channel 0 when none is selected
    function automatic logic [2:0] first_ch(input logic [7:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // next selected channel above cur, wrapping to the lowest
    function automatic logic [2:0] next_ch(input logic [7:0] m, input logic [2:0] cur);
        logic [2:0] r;
        r = first_ch(m);
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && (3'(i) > cur)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // next state of the whole block
    always_comb begin
        d = q;
        trig_raw = '0;
        trig_raw[adctr_pkg::TR_EXT0] = ext_trigger_in0_in;
        trig_raw[adctr_pkg::TR_CMP] = comparator_in;
        trig_raw[adctr_pkg::TR_EXT1] = ext_trigger_in1_in;
        trig_raw[adctr_pkg::TR_WT0] = wide_timer_match0_in;
        trig_raw[adctr_pkg::TR_WT1] = wide_timer_match1_in;
        trig_raw[adctr_pkg::TR_NT0] = narrow_timer_match0_in;
        trig_raw[adctr_pkg::TR_NT1] = narrow_timer_match1_in;
        start_code = q.ctrl[adctr_pkg::START_LSB +: 4];
        burst = q.ctrl[adctr_pkg::BURST_BIT];
        sel_mask = q.ctrl[adctr_pkg::SEL_LSB +: 8];
        new_sel = pwdata_in[adctr_pkg::SEL_LSB +: 8];
        acc_first = psel_in && penable_in && !q.pready;
        acc_end = psel_in && penable_in && q.pready;
        wr_ctrl = acc_end && pwrite_in && (paddr_in == adctr_pkg::ADDR_CTRL);
        rd_gres = acc_first && !pwrite_in && (paddr_in == adctr_pkg::ADDR_GRES);
        go = 1'b0;
        go_ch = first_ch(sel_mask);
        nxt = next_ch(sel_mask, q.ch);

        // pins cross in through two flops; only stage two is read
        d.sync1 = trig_raw;
        d.sync2 = q.sync1;

        // pick the trigger source named by the start code
        trig_ok = 1'b1;
        case (start_code)
            adctr_pkg::ST_EXT0: trig_sel = q.sync2[adctr_pkg::TR_EXT0];
            adctr_pkg::ST_EXT1: trig_sel = q.sync2[adctr_pkg::TR_EXT1];
            adctr_pkg::ST_CMP: trig_sel = q.sync2[adctr_pkg::TR_CMP];
            adctr_pkg::ST_WT0: trig_sel = q.sync2[adctr_pkg::TR_WT0];
            adctr_pkg::ST_WT1: trig_sel = q.sync2[adctr_pkg::TR_WT1];
            adctr_pkg::ST_NT0: trig_sel = q.sync2[adctr_pkg::TR_NT0];
            adctr_pkg::ST_NT1: trig_sel = q.sync2[adctr_pkg::TR_NT1];
            default: begin
                // no start, start now and reserved codes never trigger
                trig_sel = 1'b0;
                trig_ok = 1'b0;
            end
        endcase
        // a change of start code may look like one edge; harmless by design
        d.trig_prev = trig_sel;
        if (q.ctrl[adctr_pkg::EDGE_BIT]) begin
            trig_edge = trig_ok && q.trig_prev && !trig_sel;
        end else begin
            trig_edge = trig_ok && !q.trig_prev && trig_sel;
        end

        // read mux, captured at the edge where the read clears its flags,
        // so a flag set after the capture is never cleared unseen
        hit = 1'b1;
        rdata = '0;
        case (paddr_in)
            adctr_pkg::ADDR_CTRL: rdata[adctr_pkg::CTRL_W-1:0] = q.ctrl;
            adctr_pkg::ADDR_GRES: begin
                rdata[adctr_pkg::RES_LSB +: 10] = q.g_res;
                rdata[adctr_pkg::CHN_LSB +: 3] = q.g_ch;
                rdata[adctr_pkg::OVR_BIT] = q.g_ovr;
                rdata[adctr_pkg::DONE_BIT] = q.g_done;
            end
            adctr_pkg::ADDR_SRC: rdata[adctr_pkg::SRC_LSB +: 6] = q.src;
            adctr_pkg::ADDR_MASK: rdata[7:0] = q.mask;
            adctr_pkg::ADDR_STAT: begin
                rdata[7:0] = q.done;
                rdata[adctr_pkg::STAT_OVR_LSB +: 8] = q.ovr;
                rdata[adctr_pkg::STAT_IRQ_BIT] = |(q.done & q.mask);
            end
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < 8; i++) begin
            if (paddr_in == adctr_pkg::ADDR_CRES0 + adctr_pkg::ADDR_STEP * 32'(i)) begin
                hit = 1'b1;
                rdata[adctr_pkg::RES_LSB +: 10] = q.res[i];
                rdata[adctr_pkg::OVR_BIT] = q.ovr[i];
                rdata[adctr_pkg::DONE_BIT] = q.done[i];
            end
        end

        // apb: one wait state, ready for one cycle
        d.pready = acc_first;
        if (acc_first) begin
            d.prdata = hit ? rdata : 32'h00000000;
            d.pslverr = !hit;
        end

        // read side effects: clears first, so a same-edge set wins
        if (rd_gres) begin
            d.g_done = 1'b0;
            d.g_ovr = 1'b0;
        end
        for (int i = 0; i < 8; i++) begin
            if (acc_first && !pwrite_in &&
                paddr_in == adctr_pkg::ADDR_CRES0 + adctr_pkg::ADDR_STEP * 32'(i)) begin
                d.done[i] = 1'b0;
                d.ovr[i] = 1'b0;
            end
        end

        // plain register writes
        if (acc_end && pwrite_in) begin
            if (paddr_in == adctr_pkg::ADDR_SRC) begin
                d.src = pwdata_in[adctr_pkg::SRC_LSB +: 6];
            end
            if (paddr_in == adctr_pkg::ADDR_MASK) begin
                d.mask = pwdata_in[7:0];
            end
        end
        if (wr_ctrl) begin
            d.g_done = 1'b0;
        end

        // conversion completion from the core
        if (q.state == adctr_pkg::ST_BUSY && core_done_in) begin
            d.state = adctr_pkg::ST_IDLE;
            d.res[q.ch] = core_result_in;
            d.done[q.ch] = 1'b1;
            if (burst && q.done[q.ch]) begin
                d.ovr[q.ch] = 1'b1; // unread result overwritten
            end
            d.g_res = core_result_in;
            d.g_ch = q.ch;
            d.g_done = 1'b1;
            if (burst && q.g_done && !rd_gres) begin
                d.g_ovr = 1'b1;
            end
            if (burst) begin
                d.ch = nxt;
                // wrap means one pass over the selection is over
                if (q.ctrl[adctr_pkg::SINGLE_BIT] && nxt <= q.ch) begin
                    d.ctrl[adctr_pkg::BURST_BIT] = 1'b0;
                end
            end
        end

        // control write: store, restart when busy, or start now
        if (wr_ctrl) begin
            d.ctrl = pwdata_in[adctr_pkg::CTRL_W-1:0];
            go_ch = first_ch(new_sel);
            d.ch = go_ch;
            if (q.state == adctr_pkg::ST_BUSY) begin
                d.g_done = 1'b1;
                go = 1'b1;
            end else if (!pwdata_in[adctr_pkg::BURST_BIT] &&
                         pwdata_in[adctr_pkg::START_LSB +: 4] == adctr_pkg::ST_NOW) begin
                go = 1'b1;
            end
        end else if (q.state == adctr_pkg::ST_IDLE) begin
            if (burst) begin
                // scan keeps going while channels are selected
                go = |sel_mask;
                go_ch = q.ch;
            end else if (trig_edge) begin
                go = 1'b1;
            end
        end

        // launch a conversion
        d.start = go;
        if (go) begin
            d.ch = go_ch;
            d.state = adctr_pkg::ST_BUSY;
        end
    end

    // register the whole state
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
            q.ctrl <= adctr_pkg::CTRL_RST;
            q.src <= adctr_pkg::SRC_RST;
            q.mask <= adctr_pkg::MASK_RST;
            q.state <= adctr_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flops
    assign prdata_out = q.prdata;
    assign pready_out = q.pready;
    assign pslverr_out = q.pslverr;
    assign conv_start_out = q.start;
    assign conv_channel_out = q.ch;
    assign converter_busy_out = (q.state == adctr_pkg::ST_BUSY);
    assign ch5_source_out = q.src[1:0];
    assign ch6_source_out = q.src[3:2];
    assign ch7_source_out = q.src[5:4];
endmodule
`default_nettype wire

// ### adctr_top_sva.sv
// assertion checker for the converter control block
`default_nettype none
module adctr_top_sva (
    input wire logic sys_clk_in, // clock
    input wire logic rst_b_in, // reset, active low
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb access
    input wire logic pwrite_in, // apb direction
    input wire logic [31:0] paddr_in, // apb address
    input wire logic [31:0] pwdata_in, // apb write data
    input wire logic [31:0] prdata_out, // apb read data
    input wire logic pready_out, // apb ready
    input wire logic conv_start_out, // start pulse
    input wire logic converter_busy_out, // core busy
    input wire logic [1:0] ch5_source_out, // channel 5 switch
    input wire logic [1:0] ch6_source_out, // channel 6 switch
    input wire logic [1:0] ch7_source_out // channel 7 switch
);
    logic fin; // a transfer completes at this edge
    logic [7:0] mask_q; // shadow of the irq mask, to judge status reads
    assign fin = psel_in && penable_in && pready_out;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // shadow follows completed mask writes only
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) mask_q <= 8'h00;
        else if (fin && pwrite_in && paddr_in == adctr_pkg::ADDR_MASK) mask_q <= pwdata_in[7:0];
    end
    property p_start_now;
        fin && pwrite_in && paddr_in == adctr_pkg::ADDR_CTRL
            && pwdata_in[26:23] == adctr_pkg::ST_NOW && !pwdata_in[16] |=> conv_start_out;
    endproperty
    a_start_now: assert property (p_start_now)
        else $error("no start after start-now write");
    property p_no_start;
        fin && pwrite_in && paddr_in == adctr_pkg::ADDR_CTRL && !converter_busy_out
            && pwdata_in[26:23] == adctr_pkg::ST_NONE && !pwdata_in[16] |=> !conv_start_out [*3];
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("start while start field is none");
    property p_src5;
        fin && pwrite_in && paddr_in == adctr_pkg::ADDR_SRC |=> ch5_source_out == $past(pwdata_in[11:10]);
    endproperty
    a_src5: assert property (p_src5)
        else $error("channel 5 switch does not follow select");
    property p_src6;
        fin && pwrite_in && paddr_in == adctr_pkg::ADDR_SRC |=> ch6_source_out == $past(pwdata_in[13:12]);
    endproperty
    a_src6: assert property (p_src6)
        else $error("channel 6 switch does not follow select");
    property p_src7;
        fin && pwrite_in && paddr_in == adctr_pkg::ADDR_SRC |=> ch7_source_out == $past(pwdata_in[15:14]);
    endproperty
    a_src7: assert property (p_src7)
        else $error("channel 7 switch does not follow select");
    property p_res_zero;
        fin && !pwrite_in && paddr_in == adctr_pkg::ADDR_GRES |-> prdata_out[5:0] == 6'h00
            && prdata_out[23:16] == 8'h00 && prdata_out[29:27] == 3'h0;
    endproperty
    a_res_zero: assert property (p_res_zero)
        else $error("unused result bits not zero");
    property p_stat_zero;
        fin && !pwrite_in && paddr_in == adctr_pkg::ADDR_STAT |-> prdata_out[31:17] == 15'h0000;
    endproperty
    a_stat_zero: assert property (p_stat_zero)
        else $error("upper status bits not zero");
    property p_irq;
        fin && !pwrite_in && paddr_in == adctr_pkg::ADDR_STAT
            |-> prdata_out[16] == |(prdata_out[7:0] & mask_q);
    endproperty
    a_irq: assert property (p_irq)
        else $error("combined flag differs from masked done flags");
    property p_one_start;
        conv_start_out |=> !conv_start_out;
    endproperty
    a_one_start: assert property (p_one_start)
        else $error("start pulse longer than one cycle");
endmodule
bind adctr_top adctr_top_sva adctr_top_sva_i (.sys_clk_in, .rst_b_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .conv_start_out,
    .converter_busy_out, .ch5_source_out, .ch6_source_out, .ch7_source_out);
`default_nettype wire

// ### adctr_top_tb_top.sv
// self-checking bench for the converter control block
`default_nettype none
module adctr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0; // clock and active-low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata; // apb address and data
    logic pready, pslverr, start, busy, done; // handshakes
    logic [6:0] trig = 7'h00; // trigger sources, package bit order
    logic [5:0] delay = 6'h02; // core answer delay
    logic [9:0] res; // core result
    logic [2:0] chan; // channel under conversion
    logic [1:0] src5, src6, src7; // analog switch settings
    int miscompares = 0, compares = 0; // mismatch and check counts
    always #2.5 clk = ~clk;
    adctr_top adctr_top_i (.sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ext_trigger_in0_in(trig[0]), .comparator_in(trig[1]), .ext_trigger_in1_in(trig[2]),
        .wide_timer_match0_in(trig[3]), .wide_timer_match1_in(trig[4]),
        .narrow_timer_match0_in(trig[5]), .narrow_timer_match1_in(trig[6]),
        .core_done_in(done), .core_result_in(res), .conv_start_out(start),
        .conv_channel_out(chan), .converter_busy_out(busy), .ch5_source_out(src5),
        .ch6_source_out(src6), .ch7_source_out(src7));
    adctr_core_model adctr_core_model_i (.clk_in(clk), .rst_b_in(rst_b), .start_in(start),
        .channel_in(chan), .delay_in(delay), .done_out(done), .result_out(res));
    // compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge, so a following call never re-drives psel in this time step
        @(posedge clk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    // read and compare the masked word
    task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(name, rd & m, e);
    endtask
    // count start pulses over a window
    task automatic starts(input int n, input int e, input string name);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clk);
            if (start === 1'b1) c++;
        end
        chk(name, c, e);
    endtask
    // bounded wait for the core to finish
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 200);
        chk("core idle", {31'h0, busy}, 32'h0);
    endtask
    // expected latest result word, done set, no loss
    function automatic logic [31:0] gres(input logic [2:0] ch);
        return {2'h2, 3'h0, ch, 8'h00, ch, 7'h55, 6'h00};
    endfunction
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog, far beyond the expected thousand cycles
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial begin
        logic [31:0] rd;
        logic err;
        int b;
        static logic [3:0] codes [9] = '{adctr_pkg::ST_EXT0, adctr_pkg::ST_CMP,
            adctr_pkg::ST_EXT1,
            adctr_pkg::ST_WT0, adctr_pkg::ST_WT1, adctr_pkg::ST_NT0, adctr_pkg::ST_NT1,
            adctr_pkg::ST_NONE, 4'h3};
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc("status reset", adctr_pkg::ADDR_STAT, 32'hFFFFFFFF, 32'h0);
        rdc("select reset", adctr_pkg::ADDR_SRC, 32'h0000FC00, 32'h0);
        for (int v = 0; v < 3; v++) begin
            wr(adctr_pkg::ADDR_SRC, {16'h0000, {3{v[1:0]}}, 10'h000});
            @(posedge clk);
            chk("switches", {26'h0, src7, src6, src5}, {26'h0, {3{v[1:0]}}});
        end
        // start at once on channel 3, then flags, mask and clearing reads
        wr(adctr_pkg::ADDR_CTRL, 32'h01000008);
        wait_idle;
        rdc("latest", adctr_pkg::ADDR_GRES, 32'hFFFFFFFF, gres(3'h3));
        rdc("latest reread", adctr_pkg::ADDR_GRES, 32'h80000000, 32'h0);
        rdc("status done", adctr_pkg::ADDR_STAT, 32'h000100FF, 32'h00000008);
        wr(adctr_pkg::ADDR_MASK, 32'h00000008);
        rdc("irq on", adctr_pkg::ADDR_STAT, 32'h000100FF, 32'h00010008);
        wr(adctr_pkg::ADDR_MASK, 32'h00000004);
        rdc("irq masked", adctr_pkg::ADDR_STAT, 32'h000100FF, 32'h00000008);
        rdc("chan 3", adctr_pkg::ADDR_CRES0 + 32'hC, 32'hC000FFC0, 32'h80007540);
        rdc("status clear", adctr_pkg::ADDR_STAT, 32'h000100FF, 32'h0);
        // control write while a slow conversion runs
        delay <= 6'h1E;
        wr(adctr_pkg::ADDR_CTRL, 32'h01000002);
        wr(adctr_pkg::ADDR_CTRL, 32'h01000004);
        rdc("done on restart", adctr_pkg::ADDR_GRES, 32'h80000000, 32'h80000000);
        wait_idle;
        rdc("restart result", adctr_pkg::ADDR_GRES, 32'hFFFFFFFF, gres(3'h2));
        // each trigger start code, none and reserved 0x3, both edges, with wrong source and wrong edge
        delay <= 6'h02;
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < 9; i++) begin
                b = (i < 7) ? i : 0;
                trig <= {7{e[0]}};
                repeat (4) @(posedge clk);
                wr(adctr_pkg::ADDR_CTRL, {4'h0, e[0], codes[i], 15'h0000, 8'h01});
                starts(8, 0, "quiet after write");
                trig[(b + 1) % 7] <= ~e[0];
                starts(8, 0, "other source");
                trig[b] <= ~e[0];
                starts(8, (i < 7) ? 1 : 0, "trigger");
                trig[b] <= e[0];
                starts(8, 0, "opposite edge");
                wait_idle;
            end
        end
        // single pass over channels 0 and 2
        wr(adctr_pkg::ADDR_CTRL, 32'h00110005);
        starts(30, 2, "single pass");
        rdc("scan bit cleared", adctr_pkg::ADDR_CTRL, 32'h00010000, 32'h0);
        for (int k = 0; k < 12; k++) apb(1'b0, adctr_pkg::ADDR_GRES + 4 * k, 32'h0, rd, err);
        // continuous scan without reading loses results
        wr(adctr_pkg::ADDR_CTRL, 32'h00010001);
        repeat (30) @(posedge clk);
        wr(adctr_pkg::ADDR_CTRL, 32'h00000001);
        wait_idle;
        rdc("status lost", adctr_pkg::ADDR_STAT, 32'h0000FFFF, 32'h00000101);
        wr(adctr_pkg::ADDR_CTRL, 32'h00000000);
        rdc("lost, done cleared", adctr_pkg::ADDR_GRES, 32'hC0000000, 32'h40000000);
        rdc("lost cleared", adctr_pkg::ADDR_GRES, 32'h40000000, 32'h0);
        // unmapped address is refused
        apb(1'b0, 32'h4001C040, 32'h0, rd, err);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
